// ===== include/rst_seq_defines.vh
`ifndef RST_SEQ_DEFINES_VH
`define RST_SEQ_DEFINES_VH

// ****************************************
// register map (byte addresses)
// ****************************************
`define ADDR_CAUSE         8'h00
`define ADDR_CONFIG        8'h04
`define ADDR_OPTION        8'h08
`define ADDR_STATUS        8'h0c

// ****************************************
// field positions and reset values
// ****************************************
`define CAUSE_BROWNOUT_BIT 0
`define CAUSE_POWERON_BIT  1
`define CAUSE_RESET        2'b00
`define CFG_POWER_UP_DELAY_TIMER_DIS_BIT   0
`define CFG_WDT_EN_BIT     1
`define CFG_BOR_MSB        3
`define CFG_BOR_LSB        2
`define CFG_LEVEL_BIT      4
`define CFG_MODE_MSB       7
`define CFG_MODE_LSB       5
`define CONFIG_RESET       8'h0f
`define OPT_PSA_BIT        3
`define OPT_RATE_MSB       2
`define OPT_RATE_LSB       0
`define OPTION_RESET       8'hff

// ****************************************
// clock modes and brown-out encodings
// ****************************************
`define MODE_LP            3'h0
`define MODE_XT            3'h1
`define MODE_HS            3'h2
`define MODE_EXT_RC        3'h3
`define MODE_INTERNAL_OSC_MODE        3'h4
`define MODE_EXT_CLK       3'h5
`define MODE_SECONDARY_TIMER_OSC         3'h6
`define BOR_ALWAYS         2'b11
`define BOR_AWAKE          2'b10
`define BOR_LEVEL_LOW      1'b0

// ****************************************
// timing
// ****************************************
`define MS_PER_S           1000
`define CLK_PERIOD_NS      50
`define WDT_OSC_HZ         31000
`define POWER_UP_DELAY_TIMER_TIME_MS       64
`define POWER_UP_DELAY_TIMER_TICKS         ((`POWER_UP_DELAY_TIMER_TIME_MS * `WDT_OSC_HZ) / `MS_PER_S)
`define OST_PERIODS        1024
`define WDT_BASE_MS        17
`define WDT_BASE_TICKS     ((`WDT_BASE_MS * `WDT_OSC_HZ) / `MS_PER_S)
`define BOR_MIN_NS         100000
`define BOR_MIN_CYC        ((`BOR_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== design/reset_timeout_watchdog_seq.v
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "rst_seq_defines.vh"

module reset_timeout_watchdog_seq (
	input  wire        CLK,
	input  wire        RSTN,
	input  wire        CE,
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [7:0]  PADDR,
	input  wire [31:0] PWDATA,
	output reg  [31:0] PRDATA,
	output reg         PREADY,
	output reg         PSLVERR,
	input  wire        POR_DETECT,
	input  wire        BROWNOUT_LOW,
	input  wire        OSC_TICK,
	input  wire        SYS_OSC_TICK,
	input  wire        EXT_RESET_N,
	input  wire        SLEEP,
	input  wire        WAKE,
	input  wire        WATCHDOG_CLEAR,
	input  wire        FLASH_ERASE,
	output reg         CORE_RESET,
	output reg         BOR_ARM,
	output reg         BOR_LEVEL,
	output reg         WDT_WAKE
);

	// ****************************************
	// constants
	// ****************************************
	localparam [3:0]  ST_HOLD = 4'h1;
	localparam [3:0]  ST_POWER_UP_DELAY_TIMER = 4'h2;
	localparam [3:0]  ST_OST  = 4'h4;
	localparam [3:0]  ST_RUN  = 4'h8;
	localparam [31:0] POWER_UP_DELAY_TIMER_N  = `POWER_UP_DELAY_TIMER_TICKS - 1;
	localparam [31:0] OST_N   = `OST_PERIODS - 1;
	localparam [31:0] WDT_N   = `WDT_BASE_TICKS - 1;
	localparam [31:0] BOR_N   = `BOR_MIN_CYC - 1;
	localparam [10:0] POWER_UP_DELAY_TIMER_LAST = POWER_UP_DELAY_TIMER_N[10:0];
	localparam [10:0] OST_LAST  = OST_N[10:0];
	localparam [9:0]  WDT_LAST  = WDT_N[9:0];
	localparam [10:0] BOR_LAST  = BOR_N[10:0];

	// ****************************************
	// decode functions
	// ****************************************
	function is_crystal;
		input [2:0] mode;
		begin
			is_crystal = (mode == `MODE_LP) || (mode == `MODE_XT) || (mode == `MODE_HS);
		end
	endfunction

	function bor_on;
		input [1:0] field;
		input       asleep;
		begin
			bor_on = (field == `BOR_ALWAYS) || ((field == `BOR_AWAKE) && !asleep);
		end
	endfunction

	function addr_ok;
		input [7:0] a;
		begin
			addr_ok = (a == `ADDR_CAUSE) || (a == `ADDR_CONFIG) ||
				(a == `ADDR_OPTION) || (a == `ADDR_STATUS);
		end
	endfunction

	// prescaler ratio is 1:2^rate when assigned, 1:1 otherwise
	function [7:0] presc_limit;
		input       assigned;
		input [2:0] sel;
		begin
			if (assigned)
				presc_limit = (8'h01 << sel) - 8'h01;
			else
				presc_limit = 8'h00;
		end
	endfunction

	// ****************************************
	// state
	// ****************************************
	reg  [1:0]  cause;
	reg  [7:0]  cfg_word;
	reg  [7:0]  option;
	reg  [3:0]  state;
	reg  [3:0]  next_state;
	reg  [10:0] power_up_delay_timer_cnt;
	reg  [10:0] ost_cnt;
	reg  [10:0] bor_cnt;
	reg  [9:0]  wdt_base;
	reg  [7:0]  wdt_pre;
	reg         wake_ost;
	reg         wdt_rst;
	reg  [31:0] rd_mux;

	// ****************************************
	// configuration fields
	// ****************************************
	wire       power_up_delay_timer_dis  = cfg_word[`CFG_POWER_UP_DELAY_TIMER_DIS_BIT];
	wire       wdt_en    = cfg_word[`CFG_WDT_EN_BIT];
	wire [1:0] bor_field = cfg_word[`CFG_BOR_MSB:`CFG_BOR_LSB];
	wire [2:0] mode      = cfg_word[`CFG_MODE_MSB:`CFG_MODE_LSB];
	wire       crystal   = is_crystal(mode);
	wire       prescaler_assign       = option[`OPT_PSA_BIT];
	wire [2:0] rate      = option[`OPT_RATE_MSB:`OPT_RATE_LSB];

	wire       bor_armed = FLASH_ERASE | bor_on(bor_field, SLEEP);
	wire       bor_trip  = bor_armed & BROWNOUT_LOW & (bor_cnt == BOR_LAST);
	wire       supply_ok = !POR_DETECT && !(bor_armed && BROWNOUT_LOW);


	// ****************************************
	// bus and sequencer decode
	// ****************************************
	wire       apb_setup  = PSEL & PENABLE & !PREADY;
	wire       apb_write  = PSEL & PENABLE & PREADY & PWRITE;
	wire       wr_cause   = apb_write && (PADDR == `ADDR_CAUSE);
	wire       wr_config  = apb_write && (PADDR == `ADDR_CONFIG);
	wire       wr_option  = apb_write && (PADDR == `ADDR_OPTION);
	wire       ost_active = (state == ST_OST) | wake_ost;
	wire       ost_done   = SYS_OSC_TICK && (ost_cnt == OST_LAST);

	// ****************************************
	// brown-out glitch filter
	// ****************************************
	// a glitch shorter than the minimum never trips, however steep the edge
	always @(posedge CLK) begin
		if (!RSTN) begin
			bor_cnt   <= 11'h000;
		end else if (CE) begin
			if (!(bor_armed && BROWNOUT_LOW))
				bor_cnt <= 11'h000;
			else if (bor_cnt != BOR_LAST)
				bor_cnt <= bor_cnt + 11'h001;
		end
	end

	// ****************************************
	// comparator control
	// ****************************************
	// erase overrides the configured level so protection logic stays covered
	always @(posedge CLK) begin
		if (!RSTN) begin
			BOR_ARM   <= 1'b0;
			BOR_LEVEL <= `BOR_LEVEL_LOW;
		end else if (CE) begin
			BOR_ARM <= bor_armed;
			if (FLASH_ERASE)
				BOR_LEVEL <= `BOR_LEVEL_LOW;
			else
				BOR_LEVEL <= cfg_word[`CFG_LEVEL_BIT];
		end
	end

	// ****************************************
	// time-out sequencer
	// ****************************************
	always @* begin
		next_state = state;
		case (state)
		ST_HOLD: begin
			if (supply_ok) begin
				if (!power_up_delay_timer_dis)
					next_state = ST_POWER_UP_DELAY_TIMER;
				else if (crystal)
					next_state = ST_OST;
				else
					next_state = ST_RUN;
			end
		end
		ST_POWER_UP_DELAY_TIMER: begin
			if (OSC_TICK && power_up_delay_timer_cnt == POWER_UP_DELAY_TIMER_LAST) begin
				if (crystal)
					next_state = ST_OST;
				else
					next_state = ST_RUN;
			end
		end
		ST_OST: begin
			if (ost_done)
				next_state = ST_RUN;
		end
		ST_RUN: begin
			next_state = ST_RUN;
		end
		default: begin
			next_state = ST_HOLD;
		end
		endcase
		if (POR_DETECT || bor_trip)
			next_state = ST_HOLD;
	end

	// external pin is not looked at here, so time-outs run on beneath it
	always @(posedge CLK) begin
		if (!RSTN) begin
			state    <= ST_HOLD;
			power_up_delay_timer_cnt <= 11'h000;
			ost_cnt  <= 11'h000;
			wake_ost <= 1'b0;
		end else if (CE) begin
			state <= next_state;
			if (next_state != ST_POWER_UP_DELAY_TIMER || state != ST_POWER_UP_DELAY_TIMER)
				power_up_delay_timer_cnt <= 11'h000;
			else if (OSC_TICK)
				power_up_delay_timer_cnt <= power_up_delay_timer_cnt + 11'h001;
			if (!ost_active || ost_done)
				ost_cnt <= 11'h000;
			else if (SYS_OSC_TICK)
				ost_cnt <= ost_cnt + 11'h001;
			if (WAKE && state == ST_RUN && crystal)
				wake_ost <= 1'b1;
			else if (ost_done || state != ST_RUN)
				wake_ost <= 1'b0;
		end
	end

	// ****************************************
	// watchdog
	// ****************************************
	// the start-up counts use their own counters; this one stays cleared until the run state
	wire       wdt_hold = !wdt_en || WATCHDOG_CLEAR || (WAKE && !crystal) ||
		wake_ost || state != ST_RUN;
	wire [7:0] pre_lim  = presc_limit(prescaler_assign, rate);
	wire       wdt_exp  = !wdt_hold && OSC_TICK && wdt_base == WDT_LAST && wdt_pre == pre_lim;

	always @(posedge CLK) begin
		if (!RSTN) begin
			wdt_base <= 10'h000;
			wdt_pre  <= 8'h00;
		end else if (CE) begin
			if (wdt_hold) begin
				wdt_base <= 10'h000;
				wdt_pre  <= 8'h00;
			end else if (OSC_TICK) begin
				if (wdt_base == WDT_LAST) begin
					wdt_base <= 10'h000;
					wdt_pre  <= (wdt_pre == pre_lim) ? 8'h00 : wdt_pre + 8'h01;
				end else begin
					wdt_base <= wdt_base + 10'h001;
				end
			end
		end
	end

	// ****************************************
	// watchdog expiry
	// ****************************************
	// expiry in sleep only wakes the core; awake it pulses the core reset
	always @(posedge CLK) begin
		if (!RSTN) begin
			wdt_rst  <= 1'b0;
			WDT_WAKE <= 1'b0;
		end else if (CE) begin
			wdt_rst  <= wdt_exp & !SLEEP;
			WDT_WAKE <= wdt_exp & SLEEP;
		end
	end

	// ****************************************
	// core reset
	// ****************************************
	wire       reset_req = (next_state != ST_RUN) ||
		!EXT_RESET_N ||
		wdt_rst;

	always @(posedge CLK) begin
		if (!RSTN) begin
			CORE_RESET <= 1'b1;
		end else if (CE) begin
			CORE_RESET <= reset_req;
		end
	end

	// ****************************************
	// reset cause flags
	// ****************************************
	// hardware clearing beats a software write in the same cycle
	always @(posedge CLK) begin
		if (!RSTN) begin
			cause <= `CAUSE_RESET;
		end else if (CE) begin
			if (POR_DETECT)
				cause[`CAUSE_POWERON_BIT] <= 1'b0;
			else if (wr_cause)
				cause[`CAUSE_POWERON_BIT] <= PWDATA[`CAUSE_POWERON_BIT];
			if (bor_trip)
				cause[`CAUSE_BROWNOUT_BIT] <= 1'b0;
			else if (wr_cause)
				cause[`CAUSE_BROWNOUT_BIT] <= PWDATA[`CAUSE_BROWNOUT_BIT];
		end
	end

	// ****************************************
	// apb slave
	// ****************************************
	always @* begin
		rd_mux = 32'h0000_0000;
		case (PADDR)
		`ADDR_CAUSE:  rd_mux[1:0] = cause;
		`ADDR_CONFIG: rd_mux[7:0] = cfg_word;
		`ADDR_OPTION: rd_mux[7:0] = option;
		`ADDR_STATUS: rd_mux[5:0] = {CORE_RESET, wake_ost, state};
		default:      rd_mux = 32'h0000_0000;
		endcase
	end

	// one wait state: pready rises the cycle after the access phase begins
	always @(posedge CLK) begin
		if (!RSTN) begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else if (CE) begin
			PREADY  <= apb_setup;
			PSLVERR <= apb_setup & !addr_ok(PADDR);
			if (apb_setup)
				PRDATA <= PWRITE ? 32'h0000_0000 : rd_mux;
		end
	end

	// ****************************************
	// configuration register
	// ****************************************
	always @(posedge CLK) begin
		if (!RSTN) begin
			cfg_word <= `CONFIG_RESET;
		end else if (CE) begin
			if (wr_config)
				cfg_word <= PWDATA[7:0];
		end
	end

	// ****************************************
	// timer option register
	// ****************************************
	always @(posedge CLK) begin
		if (!RSTN) begin
			option <= `OPTION_RESET;
		end else if (CE) begin
			if (wr_option)
				option <= PWDATA[7:0];
		end
	end

endmodule // reset_timeout_watchdog_seq

`default_nettype wire

// ===== testbench/rst_seq_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// reset sequencing and bus checks
// ****
module rst_seq_checker (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PREADY,
	input wire logic POR_DETECT,
	input wire logic BROWNOUT_LOW,
	input wire logic EXT_RESET_N,
	input wire logic FLASH_ERASE,
	input wire logic CORE_RESET,
	input wire logic BOR_ARM,
	input wire logic BOR_LEVEL
);
	logic [11:0] low_run;
	// saturate so a long sag never wraps under the trip mark
	always @(posedge CLK)
		if (!RSTN || !(BROWNOUT_LOW && BOR_ARM))
			low_run <= 12'h000;
		else if (low_run != 12'hfff)
			low_run <= low_run + 12'h001;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	a_por_holds_core: assert property (POR_DETECT |=> CORE_RESET)
		else $error("core reset low during power-on");
	a_pin_holds_core: assert property (!EXT_RESET_N |=> CORE_RESET)
		else $error("core reset low with pin low");
	a_release_needs_pin: assert property ($fell(CORE_RESET) |-> $past(EXT_RESET_N) && !$past(POR_DETECT))
		else $error("core reset released without pin high");
	a_erase_forces_bor: assert property (FLASH_ERASE |=> BOR_ARM && !BOR_LEVEL)
		else $error("erase did not arm lowest trip");
	a_sag_trips_reset: assert property (low_run >= 12'h7e0 |-> CORE_RESET)
		else $error("long sag did not reset");
	a_one_wait_state: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("ready not one cycle after access");
	a_ready_one_cycle: assert property (PREADY |=> !PREADY)
		else $error("ready longer than one cycle");
	a_ready_in_access: assert property (PREADY |-> $past(PSEL) && $past(PENABLE))
		else $error("ready outside access phase");
endmodule // rst_seq_checker
bind reset_timeout_watchdog_seq rst_seq_checker u_rst_seq_checker (.CLK, .RSTN, .PSEL, .PENABLE, .PREADY,
	.POR_DETECT, .BROWNOUT_LOW, .EXT_RESET_N, .FLASH_ERASE, .CORE_RESET, .BOR_ARM, .BOR_LEVEL);
`default_nettype wire

// ===== testbench/supply_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// supply comparators, oscillators, reset pin
// ****
module supply_osc_model (
	input  wire logic CLK,
	input  wire logic por_req,
	input  wire logic bo_req,
	input  wire logic pin_low,
	output var  logic POR_DETECT,
	output var  logic BROWNOUT_LOW,
	output var  logic OSC_TICK,
	output var  logic SYS_OSC_TICK,
	output var  logic EXT_RESET_N
);
	initial begin
		POR_DETECT = 1'b0;
		BROWNOUT_LOW = 1'b0;
		OSC_TICK = 1'b0;
		SYS_OSC_TICK = 1'b0;
		EXT_RESET_N = 1'b1;
	end
	// ticks every other cycle keep the long counts short
	always @(posedge CLK) begin
		POR_DETECT <= por_req;
		BROWNOUT_LOW <= bo_req;
		EXT_RESET_N <= ~pin_low;
		OSC_TICK <= ~OSC_TICK;
		SYS_OSC_TICK <= OSC_TICK;
	end
endmodule // supply_osc_model
`default_nettype wire

// ===== testbench/reset_timeout_watchdog_seq_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rst_seq_defines.vh"
// ****
// bench
// ****
module reset_timeout_watchdog_seq_tb;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        sleep = 1'b0;
	logic        erase = 1'b0;
	logic        por_req = 1'b0;
	logic        bo_req = 1'b0;
	logic        pin_low = 1'b0;
	logic        wake = 1'b0;
	logic        wdclr = 1'b0;
	wire         wdt_wk;
	wire  [31:0] prdata;
	wire         pready, pslverr, por, bo, osc, sosc, xrst_n, core_rst, arm, lvl;
	logic [33:0] exp_q[$];
	logic [33:0] note;
	logic [7:0]  seed = 8'h2f;
	int          err_count = 0;
	int          samples_checked = 0;
	always #25 clk = ~clk;
	reset_timeout_watchdog_seq u_reset_timeout_watchdog_seq (
		.CLK(clk), .RSTN(rstn), .CE(1'b1), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.POR_DETECT(por), .BROWNOUT_LOW(bo), .OSC_TICK(osc), .SYS_OSC_TICK(sosc), .EXT_RESET_N(xrst_n),
		.SLEEP(sleep), .WAKE(wake), .WATCHDOG_CLEAR(wdclr), .FLASH_ERASE(erase),
		.CORE_RESET(core_rst), .BOR_ARM(arm), .BOR_LEVEL(lvl), .WDT_WAKE(wdt_wk));
	supply_osc_model u_supply_osc_model (.CLK(clk), .por_req(por_req), .bo_req(bo_req), .pin_low(pin_low),
		.POR_DETECT(por), .BROWNOUT_LOW(bo), .OSC_TICK(osc), .SYS_OSC_TICK(sosc), .EXT_RESET_N(xrst_n));
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
		input logic er);
		int n;
		exp_q.push_back({~w, er, e});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			err_count++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic settle(input int lo, input int hi);
		int n;
		n = 0;
		while (core_rst !== 1'b0 && n < hi) begin
			@(posedge clk);
			n++;
		end
		samples_checked++;
		if (n < lo || n >= hi) begin
			err_count++;
			$display("[ERR] release delay expected %0d..%0d seen %0d", lo, hi, n);
		end
	endtask
	task automatic wdt_wait(input logic slp, input int lo, input int hi);
		int n;
		n = 0;
		while ((slp ? wdt_wk : core_rst) !== 1'b1 && n < hi) begin
			@(posedge clk);
			n++;
		end
		samples_checked++;
		if (n < lo || n >= hi) begin
			err_count++;
			$display("[ERR] watchdog expiry expected %0d..%0d seen %0d", lo, hi, n);
		end
	endtask
	task automatic pulse_in(input logic clr);
		if (clr)
			wdclr <= 1'b1;
		else
			wake <= 1'b1;
		@(posedge clk);
		wdclr <= 1'b0;
		wake <= 1'b0;
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// bus results are judged where they appear, against the oldest note
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1) begin
			note = exp_q.pop_front();
			if (note[33])
				cmp("prdata", note[31:0], prdata);
			cmp("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
		end
	end
	initial begin
		#2500000;
		err_count++;
		stop_test();
	end
	initial begin
		tick(2);
		rstn <= 1'b1;
		tick(1);
		apb(0, `ADDR_CONFIG, 0, `CONFIG_RESET, 0);
		apb(0, `ADDR_OPTION, 0, `OPTION_RESET, 0);
		apb(1, 8'h14, 32'hff, 0, 1);
		apb(0, 8'h10, 0, 0, 1);
		cmp("bor_arm", 1, arm);
		for (int f = 0; f < 8; f++) begin
			sleep <= f[2];
			apb(1, `ADDR_CONFIG, {seed, 16'h0, 3'h5, f[2], f[1:0], 2'b01}, 0, 0);
			seed = lfsr(seed);
			tick(1);
			cmp("bor_arm", {31'h0, f[1] & (f[0] | ~f[2])}, arm);
			cmp("bor_level", {31'h0, f[2]}, lvl);
		end
		erase <= 1'b1;
		tick(2);
		cmp("erase_arm", 1, {lvl, arm});
		erase <= 1'b0;
		sleep <= 1'b0;
		por_req <= 1'b1;
		tick(4);
		cmp("core_reset", 1, core_rst);
		por_req <= 1'b0;
		settle(0, 5);
		apb(1, `ADDR_CAUSE, {seed, 24'h3}, 0, 0);
		apb(0, `ADDR_CAUSE, 0, 3, 0);
		apb(1, `ADDR_CONFIG, 32'hac, 0, 0);
		bo_req <= 1'b1;
		tick(2030);
		cmp("core_reset", 1, core_rst);
		bo_req <= 1'b0;
		tick(1000);
		bo_req <= 1'b1;
		tick(2030);
		bo_req <= 1'b0;
		settle(3950, 4000);
		apb(0, `ADDR_CAUSE, 0, 2, 0);
		apb(1, `ADDR_CONFIG, 32'h0c, 0, 0);
		por_req <= 1'b1;
		tick(4);
		por_req <= 1'b0;
		settle(5990, 6060);
		apb(0, `ADDR_CAUSE, 0, 0, 0);
		apb(1, `ADDR_CONFIG, 32'hac, 0, 0);
		pin_low <= 1'b1;
		por_req <= 1'b1;
		tick(4);
		por_req <= 1'b0;
		tick(5000);
		cmp("core_reset", 1, core_rst);
		pin_low <= 1'b0;
		settle(0, 4);
		apb(1, `ADDR_OPTION, 32'h00, 0, 0);
		apb(1, `ADDR_CONFIG, {seed, 24'ha3}, 0, 0);
		seed = lfsr(seed);
		wdt_wait(0, 1000, 1100);
		repeat (3) begin
			tick(800);
			pulse_in(1);
		end
		wdt_wait(0, 1000, 1100);
		apb(1, `ADDR_OPTION, 32'h09, 0, 0);
		pulse_in(1);
		wdt_wait(0, 2050, 2200);
		sleep <= 1'b1;
		pulse_in(0);
		wdt_wait(1, 2050, 2200);
		apb(1, `ADDR_CONFIG, 32'h03, 0, 0);
		pulse_in(0);
		wdt_wait(1, 4100, 4300);
		stop_test();
	end
endmodule // reset_timeout_watchdog_seq_tb
`default_nettype wire
